// ---- logic/fieldbus_comm_timeout_monitor.sv ----
// fieldbus communication timeout monitor: scan and channel watchdogs, login lock, save tracking
`timescale 1ns/100ps
`default_nettype none

module fieldbus_comm_timeout_monitor #(
    parameter int MS_DIV = comm_timeout_pkg::MS_CYCLES
) (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    // parameter access
    input wire comm_timeout_pkg::param_wr_t wr_i,
    input wire logic [15:0] rd_addr_i,
    output logic [15:0] rd_data_o,
    // traffic events
    input wire logic scan_msg_i,
    input wire logic req_valid_i,
    input wire logic [3:0] req_channel_i,
    input wire logic port_link_up_i,
    // storage control
    input wire logic save_i,
    input wire logic factory_restore_i,
    // login
    input wire logic login_try_i,
    input wire logic [31:0] login_pw_i,
    input wire logic pw_change_i,
    input wire logic [31:0] pw_new_i,
    output logic login_ok_o,
    // status
    output comm_timeout_pkg::mon_status_t status_o,
    output logic abort_o
);
    import comm_timeout_pkg::*;

    initial begin
        if (MS_DIV < 2) begin
            $error("MS_DIV must be at least 2");
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // millisecond tick
    logic [31:0] div_q;
    logic ms_tick_q;
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            div_q <= 32'h0;
            ms_tick_q <= 1'b0;
        end else if (div_q == 32'(MS_DIV - 1)) begin
            div_q <= 32'h0;
            ms_tick_q <= 1'b1;
        end else begin
            div_q <= div_q + 32'h1;
            ms_tick_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // working registers and saved copies
    logic [15:0] scan_period_q;
    logic [15:0] chan_period_q;
    logic [15:0] scan_saved_q;
    logic [15:0] chan_saved_q;
    logic [3:0] sup_channel_q;
    logic in_range;
    logic wr_scan;
    logic wr_chan;
    assign in_range = wr_i.data <= PERIOD_MAX; // out of range writes are ignored
    assign wr_scan = wr_i.valid && wr_i.addr == SCAN_TIMEOUT_OFS && in_range;
    assign wr_chan = wr_i.valid && wr_i.addr == CHANNEL_TIMEOUT_OFS && in_range;

    // writes land in working storage only
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i || factory_restore_i) begin
            scan_period_q <= SCAN_TIMEOUT_RST;
            chan_period_q <= CHANNEL_TIMEOUT_RST;
            sup_channel_q <= 4'h0;
        end else begin
            if (wr_scan) begin
                scan_period_q <= wr_i.data;
            end
            if (wr_chan) begin
                chan_period_q <= wr_i.data;
                sup_channel_q <= wr_i.channel;
            end
        end
    end

    // nonvolatile copy updated only on save, factory restore or system reset
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i || factory_restore_i) begin
            scan_saved_q <= SCAN_TIMEOUT_RST;
            chan_saved_q <= CHANNEL_TIMEOUT_RST;
        end else if (save_i) begin
            scan_saved_q <= scan_period_q;
            chan_saved_q <= chan_period_q;
        end
    end

    // read mux, unmapped reads as zero
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            rd_data_o <= 16'h0;
        end else begin
            case (rd_addr_i)
                SCAN_TIMEOUT_OFS: rd_data_o <= scan_period_q;
                CHANNEL_TIMEOUT_OFS: rd_data_o <= chan_period_q;
                default: rd_data_o <= 16'h0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // scan watchdog
    typedef enum logic [1:0] {SCAN_IDLE, SCAN_ARMED, SCAN_TRIPPED} scan_state_t;
    scan_state_t scan_st_q;
    logic [15:0] scan_cnt_q;
    logic scan_err_q;
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i || scan_period_q == 16'h0 || wr_scan) begin
            scan_st_q <= SCAN_IDLE;
            scan_cnt_q <= 16'h0;
        end else begin
            case (scan_st_q)
                SCAN_IDLE, SCAN_TRIPPED: begin
                    if (scan_msg_i) begin
                        scan_st_q <= SCAN_ARMED;
                        scan_cnt_q <= 16'h0;
                    end
                end
                SCAN_ARMED: begin
                    if (scan_msg_i) begin
                        scan_cnt_q <= 16'h0;
                    end else if (ms_tick_q) begin
                        if (scan_cnt_q + 16'h1 >= scan_period_q) begin
                            scan_st_q <= SCAN_TRIPPED;
                        end
                        scan_cnt_q <= scan_cnt_q + 16'h1;
                    end
                end
                default: scan_st_q <= SCAN_IDLE;
            endcase
        end
    end

    // sticky guard error, cleared by disabling or rewriting the period
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            scan_err_q <= 1'b0;
        end else if (scan_st_q == SCAN_ARMED && !scan_msg_i && ms_tick_q
                     && scan_period_q != 16'h0
                     && scan_cnt_q + 16'h1 >= scan_period_q) begin
            scan_err_q <= 1'b1;
        end else if (scan_period_q == 16'h0 || wr_scan) begin
            scan_err_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // channel watchdog
    logic [15:0] chan_cnt_q;
    logic chan_err_q;
    logic chan_hit;
    logic chan_expire;
    assign chan_hit = req_valid_i && req_channel_i == sup_channel_q;
    assign chan_expire = chan_period_q != 16'h0 && !chan_hit && ms_tick_q
                         && chan_cnt_q + 16'h1 >= chan_period_q;
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i || chan_period_q == 16'h0 || wr_chan || chan_hit) begin
            chan_cnt_q <= 16'h0;
        end else if (ms_tick_q && !chan_err_q) begin
            chan_cnt_q <= chan_cnt_q + 16'h1;
        end
    end

    // error stands until the period is rewritten or disabled; abort pulses for one cycle
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            chan_err_q <= 1'b0;
            abort_o <= 1'b0;
        end else if (chan_expire && !chan_err_q) begin
            chan_err_q <= 1'b1;
            abort_o <= 1'b1;
        end else if (chan_period_q == 16'h0 || wr_chan) begin
            chan_err_q <= 1'b0;
            abort_o <= 1'b0;
        end else begin
            abort_o <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // login lockout and password
    logic [1:0] fail_cnt_q;
    logic [31:0] password_q;
    logic locked;
    assign locked = fail_cnt_q == LOGIN_FAIL_LIMIT;
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i || factory_restore_i) begin
            password_q <= PASSWORD_DEFAULT;
        end else if (pw_change_i && login_ok_o) begin
            password_q <= pw_new_i;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i || factory_restore_i) begin
            fail_cnt_q <= 2'h0;
            login_ok_o <= 1'b0;
        end else if (login_try_i && !locked) begin
            if (login_pw_i == password_q) begin
                fail_cnt_q <= 2'h0;
                login_ok_o <= 1'b1;
            end else begin
                fail_cnt_q <= fail_cnt_q + 2'h1;
                login_ok_o <= 1'b0;
            end
        end else if (locked) begin
            login_ok_o <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // status register
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            status_o <= '0;
        end else begin
            status_o.scan_armed <= scan_st_q == SCAN_ARMED;
            status_o.scan_error <= scan_err_q;
            status_o.chan_error <= chan_err_q;
            status_o.err_class <= chan_err_q ? CHANNEL_ERR_CLASS : 2'h0;
            status_o.link_lost <= !port_link_up_i;
            status_o.login_locked <= locked;
            status_o.unsaved <= scan_period_q != scan_saved_q
                                || chan_period_q != chan_saved_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // assertions, all on the core clock and quiet while reset is held
    sequence s_scan_trip;
        scan_st_q == SCAN_ARMED && !scan_msg_i && ms_tick_q && scan_period_q != 16'h0
            && scan_cnt_q + 16'h1 >= scan_period_q;
    endsequence

    a_scan_range_kept: assert property (
        @(posedge core_clk_i) disable iff (sys_rst_i)
        scan_period_q <= PERIOD_MAX) else $error("scan period out of range");
    a_scan_wait_first: assert property (
        @(posedge core_clk_i) disable iff (sys_rst_i)
        scan_st_q == SCAN_IDLE && !scan_msg_i |=> scan_st_q != SCAN_ARMED)
        else $error("scan armed without message");
    a_scan_stay_unarmed: assert property (
        @(posedge core_clk_i) disable iff (sys_rst_i)
        scan_st_q == SCAN_TRIPPED && !scan_msg_i |=> scan_st_q != SCAN_ARMED)
        else $error("scan rearmed without message");
    a_scan_trip_error: assert property (
        @(posedge core_clk_i) disable iff (sys_rst_i)
        s_scan_trip |=> scan_err_q ##1 status_o.scan_error)
        else $error("scan timeout not flagged");
    a_chan_other_ignored: assert property (
        @(posedge core_clk_i) disable iff (sys_rst_i)
        req_valid_i && req_channel_i != sup_channel_q && ms_tick_q && !chan_err_q
        && chan_period_q != 16'h0 && !wr_chan |=> chan_cnt_q == $past(chan_cnt_q) + 16'h1)
        else $error("other channel reset timer");
    a_chan_hit_restart: assert property (
        @(posedge core_clk_i) disable iff (sys_rst_i)
        chan_hit |=> chan_cnt_q == 16'h0) else $error("supervised request kept timer");
    a_chan_abort_class: assert property (
        @(posedge core_clk_i) disable iff (sys_rst_i)
        chan_expire && !chan_err_q |=> abort_o ##1 status_o.err_class == CHANNEL_ERR_CLASS)
        else $error("channel expiry not reported");
    a_chan_zero_off: assert property (
        @(posedge core_clk_i) disable iff (sys_rst_i)
        chan_period_q == 16'h0 |=> !chan_err_q) else $error("disabled channel raised error");
    a_both_off_quiet: assert property (
        @(posedge core_clk_i) disable iff (sys_rst_i)
        scan_period_q == 16'h0 && chan_period_q == 16'h0 |=> !scan_err_q && !chan_err_q)
        else $error("error raised with both watchdogs off");
    a_link_loss_seen: assert property (
        @(posedge core_clk_i) disable iff (sys_rst_i)
        !port_link_up_i |=> status_o.link_lost) else $error("link loss not reported");
    a_login_lock_three: assert property (
        @(posedge core_clk_i) disable iff (sys_rst_i)
        locked && !factory_restore_i |=> !login_ok_o) else $error("login granted while locked");
    a_save_only_copy: assert property (
        @(posedge core_clk_i) disable iff (sys_rst_i)
        !save_i && !factory_restore_i |=> scan_saved_q == $past(scan_saved_q))
        else $error("saved copy changed without save");
    a_unsaved_flag: assert property (
        @(posedge core_clk_i) disable iff (sys_rst_i)
        scan_period_q != scan_saved_q |=> status_o.unsaved) else $error("unsaved not flagged");
    a_pw_restore_default: assert property (
        @(posedge core_clk_i) disable iff (sys_rst_i)
        factory_restore_i |=> password_q == PASSWORD_DEFAULT) else $error("password not restored");
    a_pw_hold_value: assert property (
        @(posedge core_clk_i) disable iff (sys_rst_i)
        !factory_restore_i && !(pw_change_i && login_ok_o) |=> password_q == $past(password_q))
        else $error("password changed without a granted change");
endmodule

`default_nettype wire

// ---- logic/comm_timeout_pkg.sv ----
// package of constants and carriers for the fieldbus communication timeout monitor
package comm_timeout_pkg;
    // register offsets (documented parameter addresses)
    localparam logic [15:0] CHANNEL_TIMEOUT_OFS = 16'h160c;
    localparam logic [15:0] SCAN_TIMEOUT_OFS = 16'h190e;
    // reset values
    localparam logic [15:0] CHANNEL_TIMEOUT_RST = 16'h0000;
    localparam logic [15:0] SCAN_TIMEOUT_RST = 16'h0000;
    // largest legal period in ms
    localparam logic [15:0] PERIOD_MAX = 16'h2710;
    // time base
    localparam int CLK_MHZ = 100;
    localparam int MS_NS = 1000000;
    localparam int CLK_PERIOD_NS = 1000 / CLK_MHZ;
    localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
    // login lockout threshold
    localparam logic [1:0] LOGIN_FAIL_LIMIT = 2'h3;
    // error class reported on channel expiry
    localparam logic [1:0] CHANNEL_ERR_CLASS = 2'h2;
    // default login secret (arbitrary value)
    localparam logic [31:0] PASSWORD_DEFAULT = 32'h5a5a1234;

    // parameter write request from the network side
    typedef struct packed {
        logic valid;
        logic [15:0] addr;
        logic [15:0] data;
        logic [3:0] channel;
    } param_wr_t;

    // status carrier
    typedef struct packed {
        logic scan_armed;
        logic scan_error;
        logic chan_error;
        logic [1:0] err_class;
        logic link_lost;
        logic login_locked;
        logic unsaved;
    } mon_status_t;
endpackage

// ---- test/net_master_model.sv ----
// partner model: network master sending scan messages and channel requests
`timescale 1ns/100ps
`default_nettype none
module net_master_model (
    // clock
    input wire logic clk_i,
    // control from the bench
    input wire logic run_i,
    input wire logic [7:0] gap_i,
    input wire logic scan_sel_i,
    input wire logic [3:0] chan_i,
    // traffic toward the monitor
    output logic scan_msg_o,
    output logic req_valid_o,
    output logic [3:0] req_channel_o
);
    logic [7:0] cnt = 8'h00;
    logic fire_q = 1'b0;
    logic [3:0] ch_q = 4'h0;
    // pacing decided on the rising edge, so bench changes never race it
    always @(posedge clk_i) begin
        cnt <= (!run_i || cnt == gap_i - 8'h01) ? 8'h00 : cnt + 8'h01;
        fire_q <= run_i && cnt == gap_i - 8'h01;
        ch_q <= chan_i;
    end
    // traffic launched on the falling edge; the channel field wanders between requests
    initial begin
        scan_msg_o = 1'b0;
        req_valid_o = 1'b0;
        req_channel_o = 4'h0;
    end
    always @(negedge clk_i) begin
        scan_msg_o <= fire_q && scan_sel_i;
        req_valid_o <= fire_q && !scan_sel_i;
        req_channel_o <= (fire_q && !scan_sel_i) ? ch_q : ~req_channel_o;
    end
endmodule
`default_nettype wire

// ---- test/fieldbus_comm_timeout_monitor_tb_top.sv ----
// testbench of the communication timeout monitor against an integer reference model
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin mismatches++; \
    $display("unexpected %s exp %0h got %0h", nm, ex, got); end end
module fieldbus_comm_timeout_monitor_tb_top;
    import comm_timeout_pkg::*;
    localparam int DIV = 10;
    logic clk = 1'b0, rst = 1'b1, run = 1'b0, sel = 1'b1, link = 1'b1;
    logic save = 1'b0, rstr = 1'b0, try_l = 1'b0, chg = 1'b0;
    logic [31:0] pw = '0, pw_new = '0, m_pw = PASSWORD_DEFAULT;
    logic [15:0] rd_addr = '0, rd_data;
    logic [7:0] gap = 8'h0a;
    logic [3:0] chan = 4'h0, rq_ch;
    logic scan, rq, ok, abort_evt;
    param_wr_t wr = '0;
    mon_status_t st;
    int mismatches = 0, total_checks = 0, aborts = 0, seed = 32'h3dd6, p;
    int m_scan = 0, m_chan = 0, s_scan = 0, s_chan = 0, m_fails = 0;
    always #5 clk = ~clk;
    // count abort pulses
    always @(posedge clk) if (abort_evt === 1'b1) aborts <= aborts + 1;
    fieldbus_comm_timeout_monitor #(.MS_DIV(DIV)) u_dut (.core_clk_i(clk), .sys_rst_i(rst),
        .wr_i(wr), .rd_addr_i(rd_addr), .rd_data_o(rd_data), .scan_msg_i(scan),
        .req_valid_i(rq), .req_channel_i(rq_ch), .port_link_up_i(link), .save_i(save),
        .factory_restore_i(rstr), .login_try_i(try_l), .login_pw_i(pw), .pw_change_i(chg),
        .pw_new_i(pw_new), .login_ok_o(ok), .status_o(st), .abort_o(abort_evt));
    net_master_model u_master (.clk_i(clk), .run_i(run), .gap_i(gap), .scan_sel_i(sel),
        .chan_i(chan), .scan_msg_o(scan), .req_valid_o(rq), .req_channel_o(rq_ch));
    ////////////////////////////////////////////////////////////////////////////////
    // bench tasks, entered and left at a falling edge from the main sequence; the watchdog calls stop_test at a rising edge
    task automatic step(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic wreg(input logic [15:0] a, input int d, input logic [3:0] c);
        wr = '{valid: 1'b1, addr: a, data: d[15:0], channel: c};
        step(1);
        wr.valid = 1'b0;
        if (d <= 10000 && a == SCAN_TIMEOUT_OFS) m_scan = d;
        if (d <= 10000 && a == CHANNEL_TIMEOUT_OFS) m_chan = d;
        step(3);
    endtask
    task automatic rreg(input logic [15:0] a, input int ex);
        rd_addr = a;
        step(1);
        `CHK("rd_data", ex[15:0], rd_data)
    endtask
    task automatic chk_unsaved;
        `CHK("unsaved", (m_scan != s_scan) || (m_chan != s_chan), st.unsaved)
    endtask
    task automatic login(input logic [31:0] v);
        logic e;
        e = 1'b0;
        pw = v;
        try_l = 1'b1;
        step(1);
        try_l = 1'b0;
        if (m_fails < 3 && v == m_pw) begin
            m_fails = 0;
            e = 1'b1;
        end else if (m_fails < 3) m_fails++;
        step(2);
        `CHK("login_ok", e, ok)
        `CHK("locked", m_fails >= 3, st.login_locked)
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // watchdog: the sequence needs under 1200 cycles
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        stop_test();
    end
    // main sequence
    initial begin
        step(20);
        rst = 1'b0;
        step(2);
        rreg(CHANNEL_TIMEOUT_OFS, 0);
        rreg(SCAN_TIMEOUT_OFS, 0);
        rreg(16'h0000, 0);
        wreg(SCAN_TIMEOUT_OFS, 10001, 4'h0);
        rreg(SCAN_TIMEOUT_OFS, m_scan);
        wreg(CHANNEL_TIMEOUT_OFS, 10001, 4'h1);
        rreg(CHANNEL_TIMEOUT_OFS, m_chan);
        wreg(SCAN_TIMEOUT_OFS, 10000, 4'h0);
        rreg(SCAN_TIMEOUT_OFS, m_scan);
        chk_unsaved();
        save = 1'b1;
        step(1);
        save = 1'b0;
        s_scan = m_scan;
        step(3);
        chk_unsaved();
        // scan watchdog with a random short period
        p = 2 + ($unsigned($random(seed)) % 3);
        wreg(SCAN_TIMEOUT_OFS, p, 4'h0);
        chk_unsaved();
        step(8 * p * DIV);
        `CHK("scan_error", 1'b0, st.scan_error)
        `CHK("scan_armed", 1'b0, st.scan_armed)
        run = 1'b1;
        step(12 * DIV);
        run = 1'b0;
        `CHK("scan_armed", 1'b1, st.scan_armed)
        `CHK("scan_error", 1'b0, st.scan_error)
        step((p - 1) * DIV);
        `CHK("scan_error", 1'b0, st.scan_error)
        for (int i = 0; i < 3 * DIV && st.scan_error !== 1'b1; i++) step(1);
        `CHK("scan_error", 1'b1, st.scan_error)
        `CHK("scan_armed", 1'b0, st.scan_armed)
        step(5 * p * DIV);
        `CHK("scan_armed", 1'b0, st.scan_armed)
        run = 1'b1;
        step(DIV + 4);
        run = 1'b0;
        `CHK("scan_armed", 1'b1, st.scan_armed)
        // link loss with both watchdogs off
        wreg(SCAN_TIMEOUT_OFS, 0, 4'h0);
        link = 1'b0;
        step(200);
        `CHK("link_lost", 1'b1, st.link_lost)
        `CHK("errors", 2'b00, {st.scan_error, st.chan_error})
        `CHK("aborts", 0, aborts)
        link = 1'b1;
        step(3);
        `CHK("link_lost", 1'b0, st.link_lost)
        // channel watchdog set over channel 5, then traffic moves to channel 3;
        // requests flow before the write because the channel timer starts at once
        sel = 1'b0;
        chan = 4'h5;
        run = 1'b1;
        step(DIV);
        wreg(CHANNEL_TIMEOUT_OFS, 2, 4'h5);
        step(10 * DIV);
        `CHK("aborts", 0, aborts)
        chan = 4'h3;
        step(4 * DIV);
        `CHK("aborts", 1, aborts)
        `CHK("chan_error", 1'b1, st.chan_error)
        `CHK("err_class", CHANNEL_ERR_CLASS, st.err_class)
        step(3 * DIV);
        run = 1'b0;
        `CHK("aborts", 1, aborts)
        // login, password change, lockout and factory restore
        login(PASSWORD_DEFAULT);
        pw_new = $random(seed);
        chg = 1'b1;
        step(1);
        chg = 1'b0;
        m_pw = pw_new;
        step(2);
        login(PASSWORD_DEFAULT);
        login(m_pw);
        repeat (3) login(m_pw ^ (32'h1 | $random(seed)));
        login(m_pw);
        rstr = 1'b1;
        step(1);
        rstr = 1'b0;
        {m_scan, m_chan, s_scan, s_chan, m_fails} = '0;
        m_pw = PASSWORD_DEFAULT;
        step(3);
        chk_unsaved();
        login(PASSWORD_DEFAULT);
        stop_test();
    end
endmodule
`default_nettype wire
